// ### design/serial_line_pkg.sv
// Package: mode encodings, pin levels and timing constants for the serial line controller
package serial_line_pkg;

	typedef enum logic [1:0] {
		mode_rs232,
		mode_diff_full,
		mode_diff_half
	} line_mode_t;

	localparam int  CLK_HZ             = 125_000_000;
	localparam int  SLOW_MAX_BAUD      = 250_000;
	localparam int  RS232_MAX_BAUD     = 1_000_000;
	localparam int  DIFF_MAX_BAUD      = 10_000_000;
	localparam int  LAMP_COUNT         = 5;
	localparam int  DIV_WIDTH          = 16;
	localparam int  DATA_BITS          = 8;
	localparam int  FIFO_DEPTH_DEFAULT = 32;
	// Shortest legal bit period in clocks at each ceiling (rounded up)
	localparam int  SLOW_MIN_DIV  = (CLK_HZ + SLOW_MAX_BAUD - 1) / SLOW_MAX_BAUD;
	localparam int  RS232_MIN_DIV = (CLK_HZ + RS232_MAX_BAUD - 1) / RS232_MAX_BAUD;
	localparam int  DIFF_MIN_DIV  = (CLK_HZ + DIFF_MAX_BAUD - 1) / DIFF_MAX_BAUD;
	localparam logic LAMP_ON        = 1'b0;
	localparam logic LAMP_OFF       = 1'b1;
	localparam logic BOARD_RESET_IDLE = 1'b1;
	localparam logic LINE_IDLE      = 1'b1;
	localparam logic [DIV_WIDTH-1:0] DIV_RESET = 16'h01F4;

endpackage : serial_line_pkg

// ### design/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,      // System clock
	input  wire logic             rst_n,    // Async reset, active low
	input  wire logic [WIDTH-1:0] in_data,  // Write data
	input  wire logic             in_valid, // Write request
	output logic                  in_ready, // Not full
	output logic      [WIDTH-1:0] out_data, // Head word
	output logic                  out_valid,// Not empty
	input  wire logic             out_ready // Read accept
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;

	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (do_wr)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_wr)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule : byte_fifo
`default_nettype wire

// ### design/serial_line_transceiver_ctrl.sv
// Controller that drives the multi-protocol line transceiver and runs the UART
`timescale 1ns/1ps
`default_nettype none
import serial_line_pkg::*;

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - RS232: fast high unless slew limited, diff low, half low
// - RS232: lane b is RTS/CTS or channel
// - RS232 1M fast, else 250k limit
// - Full duplex: fast high unless slew limited, diff high
// - Half duplex: diff and half high, fast high unless slew limited
// - Differential: input b is driver enable
// - Differential: receive only from output b
// - Half duplex: enable drives direction, default off
// - Differential 10M fast, else 250k limit
// - Lamp lights when its pin is low
// - Board reset request held high
// - Unused lamps driven high
module serial_line_transceiver_ctrl
	import serial_line_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
	input  wire logic                  clk,                   // 125 MHz clock
	input  wire logic                  rst_n,                 // Async reset, active low
	// User side
	input  wire line_mode_t            mode_req,              // Requested line mode
	input  wire logic                  slow_slew_req,         // Request slew limiting
	input  wire logic [DIV_WIDTH-1:0]  baud_div,              // Clocks per bit
	input  wire logic                  aux_mode_flow,         // RS232 lane b: 1 RTS/CTS, 0 channel
	input  wire logic                  respond_req,           // Half duplex: allowed to talk
	input  wire logic [DATA_BITS-1:0]  tx_data,               // Byte to send
	input  wire logic                  tx_valid,              // Byte offered
	output logic                       tx_ready,              // FIFO has room
	output logic [DATA_BITS-1:0]       rx_data,               // Received byte
	output logic                       rx_valid,              // One-cycle received pulse
	output logic                       rx_frame_err,          // Stop bit low, pulse
	input  wire logic                  aux_tx,                // RS232 lane b data/RTS
	output logic                       aux_rx,                // RS232 lane b data/CTS
	input  wire logic [LAMP_COUNT-1:0] lamp_on,               // Lamp requests, high lights
	output logic                       mode_busy,             // Mode change pending
	output logic                       baud_too_fast,         // Divider below legal floor
	// Transceiver side
	output logic                       fast_slew_select,      // Slew-fast select
	output logic                       diff_protocol_select,  // Differential protocol
	output logic                       half_duplex_select,    // Half duplex
	output logic                       tx_logic_in_a,         // Serial data out
	output logic                       tx_logic_in_b,         // RS232 lane b or driver enable
	input  wire logic                  rx_logic_out_a,        // RS232 lane a receive
	input  wire logic                  rx_logic_out_b,        // Lane b / differential receive
	output logic [LAMP_COUNT-1:0]      status_lamp_n,         // Lamps, active low
	output logic                       board_reset_request_n  // Board reset, held high
);
	typedef enum logic [1:0] {tx_idle, tx_start, tx_bits, tx_stop} tx_state_t;
	typedef enum logic [1:0] {rx_idle, rx_start, rx_bits, rx_stop} rx_state_t;

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic ra_s1, ra_s2, rb_s1, rb_s2;
	// Lane choice trails the protocol pin by the synchroniser depth, so a
	// mode switch never shows the old lane's level as a start bit
	logic lane_b_d1, lane_b_d2;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{ra_s1, ra_s2, rb_s1, rb_s2} <= {4{LINE_IDLE}};
			lane_b_d1                    <= 1'b0;
			lane_b_d2                    <= 1'b0;
		end else begin
			{ra_s1, ra_s2} <= {rx_logic_out_a, ra_s1};
			{rb_s1, rb_s2} <= {rx_logic_out_b, rb_s1};
			lane_b_d1      <= diff_protocol_select;
			lane_b_d2      <= lane_b_d1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Mode
	line_mode_t mode;
	logic       slow;
	tx_state_t  tst;
	rx_state_t  rst_s;
	logic       tx_logic_in_b_drv;
	wire        diff_mode = (mode != mode_rs232);
	wire        line_quiet = (tst == tx_idle) && (rst_s == rx_idle) && !tx_logic_in_b_drv;
	wire        mode_change = (mode_req != mode) || (slow_slew_req != slow);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= mode_rs232;
			slow <= 1'b0;
		end else if (mode_change && (line_quiet || !diff_mode)
				&& tst == tx_idle && rst_s == rx_idle) begin
			mode <= mode_req;
			slow <= slow_slew_req;
		end
	end

	wire next_fast = !slow;
	wire next_diff = (mode != mode_rs232);
	wire next_half = (mode == mode_diff_half);

	// Bit period floor depends on mode and slew setting
	wire [DIV_WIDTH-1:0] min_div = slow ? DIV_WIDTH'(SLOW_MIN_DIV)
		: diff_mode ? DIV_WIDTH'(DIFF_MIN_DIV) : DIV_WIDTH'(RS232_MIN_DIV);
	wire [DIV_WIDTH-1:0] eff_div = (baud_div < min_div) ? min_div : baud_div;

	//////////////////////////////////////////////////////////////////////////
	// Transmit FIFO
	logic [DATA_BITS-1:0] f_data;
	logic                 f_valid;
	logic                 f_ready;

	byte_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.in_data  (tx_data),
		.in_valid (tx_valid),
		.in_ready (tx_ready),
		.out_data (f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);

	//////////////////////////////////////////////////////////////////////////
	// Transmitter
	logic [DIV_WIDTH-1:0] tcnt;
	logic [2:0]           tbit;
	logic [DATA_BITS-1:0] tsh;
	logic                 tline;
	wire                  ra_cts = rb_s2;  // CTS arrives on lane b, low means clear
	wire                  cts_ok = !(mode == mode_rs232 && aux_mode_flow) || !ra_cts;
	wire                  half_hold = (mode == mode_diff_half) && !respond_req;
	wire                  may_start = f_valid && cts_ok && !half_hold && !mode_change;
	wire                  tick = (tcnt == '0);

	assign f_ready = (tst == tx_idle) && may_start;

	tx_state_t            next_tst;
	logic [DIV_WIDTH-1:0] next_tcnt;
	logic [2:0]           next_tbit;
	logic [DATA_BITS-1:0] next_tsh;
	logic                 next_tline;

	always_comb begin
		next_tst   = tst;
		next_tcnt  = tick ? eff_div - 1'b1 : tcnt - 1'b1;
		next_tbit  = tbit;
		next_tsh   = tsh;
		next_tline = tline;
		case (tst)
			tx_idle: if (may_start) begin
				next_tst   = tx_start;
				next_tsh   = f_data;
				next_tcnt  = eff_div - 1'b1;
				next_tline = 1'b0;
			end
			tx_start: if (tick) begin
				next_tst   = tx_bits;
				next_tline = tsh[0];
				next_tsh   = tsh >> 1;
				next_tbit  = '0;
			end
			tx_bits: if (tick) begin
				if (tbit == 3'(DATA_BITS-1)) begin
					next_tst   = tx_stop;
					next_tline = LINE_IDLE;
				end else begin
					next_tline = tsh[0];
					next_tsh   = tsh >> 1;
					next_tbit  = tbit + 1'b1;
				end
			end
			tx_stop: if (tick)
				next_tst = tx_idle;
			default: next_tst = tx_idle;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tst   <= tx_idle;
			tcnt  <= '0;
			tbit  <= '0;
			tsh   <= '0;
			tline <= LINE_IDLE;
		end else begin
			tst   <= next_tst;
			tcnt  <= next_tcnt;
			tbit  <= next_tbit;
			tsh   <= next_tsh;
			tline <= next_tline;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Receiver: lane a in RS232, lane b in differential modes
	wire rx_line = lane_b_d2 ? rb_s2 : ra_s2;
	// Half duplex receive sees our own driving; ignore it while enabled
	wire rx_blank = (mode == mode_diff_half) && tx_logic_in_b_drv;
	logic [DIV_WIDTH-1:0] rcnt;
	logic [2:0]           rbit;
	logic [DATA_BITS-1:0] rsh;
	wire                  rtick = (rcnt == '0);

	rx_state_t            next_rst_s;
	logic [DIV_WIDTH-1:0] next_rcnt;
	logic [2:0]           next_rbit;
	logic [DATA_BITS-1:0] next_rsh;
	logic [DATA_BITS-1:0] next_rx_data;
	logic                 next_rx_valid;
	logic                 next_rx_frame_err;

	always_comb begin
		next_rst_s        = rst_s;
		next_rcnt         = rtick ? eff_div - 1'b1 : rcnt - 1'b1;
		next_rbit         = rbit;
		next_rsh          = rsh;
		next_rx_data      = rx_data;
		next_rx_valid     = 1'b0;
		next_rx_frame_err = 1'b0;
		case (rst_s)
			rx_idle: if (!rx_line && !rx_blank) begin
				next_rst_s = rx_start;
				next_rcnt  = DIV_WIDTH'(eff_div >> 1);
			end
			rx_start: if (rtick) begin
				next_rst_s = rx_line ? rx_idle : rx_bits;
				next_rbit  = '0;
			end
			rx_bits: if (rtick) begin
				next_rsh = {rx_line, rsh[DATA_BITS-1:1]};
				if (rbit == 3'(DATA_BITS-1))
					next_rst_s = rx_stop;
				else
					next_rbit = rbit + 1'b1;
			end
			rx_stop: if (rtick) begin
				next_rst_s        = rx_idle;
				next_rx_data      = rsh;
				next_rx_valid     = rx_line;
				next_rx_frame_err = !rx_line;
			end
			default: next_rst_s = rx_idle;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s        <= rx_idle;
			rcnt         <= '0;
			rbit         <= '0;
			rsh          <= '0;
			rx_data      <= '0;
			rx_valid     <= 1'b0;
			rx_frame_err <= 1'b0;
		end else begin
			rst_s        <= next_rst_s;
			rcnt         <= next_rcnt;
			rbit         <= next_rbit;
			rsh          <= next_rsh;
			rx_data      <= next_rx_data;
			rx_valid     <= next_rx_valid;
			rx_frame_err <= next_rx_frame_err;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Pin drive, every output registered
	// Driver enable high only while a frame leaves, so a slave stays quiet
	wire next_b = diff_mode ? (tst != tx_idle) : aux_tx;
	assign tx_logic_in_b_drv = tx_logic_in_b;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_slew_select      <= 1'b1;
			diff_protocol_select  <= 1'b0;
			half_duplex_select    <= 1'b0;
			tx_logic_in_a         <= LINE_IDLE;
			tx_logic_in_b         <= 1'b0;
			aux_rx                <= LINE_IDLE;
			status_lamp_n         <= {LAMP_COUNT{LAMP_OFF}};
			board_reset_request_n <= BOARD_RESET_IDLE;
			mode_busy             <= 1'b0;
			baud_too_fast         <= 1'b0;
		end else begin
			fast_slew_select      <= next_fast;
			diff_protocol_select  <= next_diff;
			half_duplex_select    <= next_half;
			tx_logic_in_a         <= tline;
			tx_logic_in_b         <= next_b;
			aux_rx                <= rb_s2;
			status_lamp_n         <= ~lamp_on;
			board_reset_request_n <= BOARD_RESET_IDLE;
			mode_busy             <= mode_change;
			baud_too_fast         <= (baud_div < min_div);
		end
	end
endmodule : serial_line_transceiver_ctrl
`default_nettype wire

// ### tb/serial_line_sva.sv
// Checker: pin-level relations of the serial line controller
`timescale 1ns/1ps
`default_nettype none
module serial_line_sva
	import serial_line_pkg::*;
(
	input wire logic                  clk,                  // Clock
	input wire logic                  rst_n,                // Reset, active low
	input wire logic [DIV_WIDTH-1:0]  baud_div,             // Clocks per bit
	input wire logic                  aux_mode_flow,        // Flow control mode
	input wire logic                  respond_req,          // Half duplex talk
	input wire logic [LAMP_COUNT-1:0] lamp_on,              // Lamp requests
	input wire logic                  baud_too_fast,        // Divider flag
	input wire logic                  fast_slew_select,     // Slew select
	input wire logic                  diff_protocol_select, // Protocol select
	input wire logic                  half_duplex_select,   // Duplex select
	input wire logic                  tx_logic_in_a,        // Serial out
	input wire logic                  tx_logic_in_b,        // Lane b or enable
	input wire logic                  rx_logic_out_b,       // Lane b receive
	input wire logic [LAMP_COUNT-1:0] status_lamp_n,        // Lamps
	input wire logic                  board_reset_request_n // Board reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence lamps_settled;
		$stable(lamp_on) [*3];
	endsequence
	// Six cycles covers the two-stage sync on the clear-to-send input
	sequence cts_held;
		(!diff_protocol_select && aux_mode_flow && rx_logic_out_b) [*6];
	endsequence
	chk_half_needs_diff: assert property (half_duplex_select |-> diff_protocol_select)
		else $error("half duplex select without protocol select");
	chk_lamps_follow: assert property (lamps_settled |-> status_lamp_n == ~lamp_on)
		else $error("lamp pins do not match requests");
	chk_board_reset_high: assert property (board_reset_request_n)
		else $error("board reset request driven low");
	chk_diff_enable_frame: assert property (diff_protocol_select && $fell(tx_logic_in_a) |-> ##[0:2] tx_logic_in_b)
		else $error("differential frame without driver enable");
	chk_half_talk_allowed: assert property (half_duplex_select && $fell(tx_logic_in_a) |-> respond_req)
		else $error("half duplex transmit without permission");
	chk_mode_pins_idle: assert property ($changed({fast_slew_select, diff_protocol_select, half_duplex_select}) |-> $past(!tx_logic_in_b) && $past(tx_logic_in_a))
		else $error("mode pins changed while line busy");
	chk_slow_baud_floor: assert property ((!fast_slew_select && baud_div < 16'h01F4) [*2] |-> baud_too_fast)
		else $error("slow slew divider below floor not flagged");
	chk_cts_holds_tx: assert property (cts_held |-> !$fell(tx_logic_in_a))
		else $error("transmit started while clear-to-send inactive");
endmodule : serial_line_sva
bind serial_line_transceiver_ctrl serial_line_sva chk (.*);
`default_nettype wire

// ### tb/line_transceiver_model.sv
// Behavioural multi-protocol line transceiver at logic levels
`timescale 1ns/1ps
`default_nettype none
module line_transceiver_model
	import serial_line_pkg::*;
(
	input  wire logic                  clk,                  // Pattern clock
	input  wire logic                  diff_protocol_select, // Protocol select
	input  wire logic                  half_duplex_select,   // Duplex select
	input  wire logic                  tx_logic_in_a,        // Transmit input a
	input  wire logic                  tx_logic_in_b,        // Transmit input b
	output logic                       rx_logic_out_a,       // Receive output a
	output logic                       rx_logic_out_b,       // Receive output b
	output logic                       line_tx_a,            // Line out a
	output logic                       line_tx_b,            // Line out b
	input  wire logic                  line_rx_a,            // Line in a
	input  wire logic                  line_rx_b,            // Line in b
	input  wire logic [LAMP_COUNT-1:0] status_lamp_n,        // Lamp pins
	output logic      [LAMP_COUNT-1:0] lamp_lit              // Lamps lit
);
	logic pat = 1'b0;
	wire  drive = diff_protocol_select ? tx_logic_in_b : 1'b1;
	// Fail-safe receiver: an undriven pair reads as idle high
	function automatic logic pair(input logic inv, input logic non);
		return (inv === 1'b1 && non === 1'b0) ? 1'b0 : 1'b1;
	endfunction : pair
	always @(posedge clk) pat <= ~pat;
	assign line_tx_a = !drive ? 1'bz : diff_protocol_select ? ~tx_logic_in_a : tx_logic_in_a;
	assign line_tx_b = !drive ? 1'bz : diff_protocol_select ? tx_logic_in_a : tx_logic_in_b;
	// Unused output toggles so the controller cannot lean on it
	assign rx_logic_out_a = diff_protocol_select ? pat : line_rx_a;
	assign rx_logic_out_b = !diff_protocol_select ? line_rx_b : half_duplex_select ?
		pair(line_tx_a, line_tx_b) : pair(line_rx_a, line_rx_b);
	assign lamp_lit = ~status_lamp_n;
endmodule : line_transceiver_model
`default_nettype wire

// ### tb/serial_line_transceiver_ctrl_tb.sv
// Testbench: controller, transceiver model and loopback cable
`timescale 1ns/1ps
`default_nettype none
module serial_line_transceiver_ctrl_tb
	import serial_line_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, slow_slew_req = 1'b0, aux_mode_flow = 1'b0;
	logic respond_req = 1'b0, tx_valid = 1'b0, aux_tx = 1'b0;
	line_mode_t mode_req = mode_rs232;
	logic [DIV_WIDTH-1:0] baud_div = 16'h007D;
	logic [7:0] tx_data = 8'h00, rx_data;
	logic [LAMP_COUNT-1:0] lamp_on = 5'h00, status_lamp_n, lamp_lit;
	logic tx_ready, rx_valid, rx_frame_err, aux_rx, mode_busy, baud_too_fast;
	logic fast_slew_select, diff_protocol_select, half_duplex_select, tx_logic_in_a;
	logic tx_logic_in_b, rx_logic_out_a, rx_logic_out_b, board_reset_request_n;
	logic line_tx_a, line_tx_b, line_rx_a, line_rx_b;
	logic [7:0] got_q[$];
	logic [7:0] exp_q[$];
	int n_fail = 0;
	int check_count = 0;
	int n_ferr = 0;
	// Loopback cable: each line output returns on its own line input
	assign line_rx_a = line_tx_a;
	assign line_rx_b = line_tx_b;
	always #4 clk = ~clk;
	serial_line_transceiver_ctrl #(.FIFO_DEPTH(32)) dut (.*);
	line_transceiver_model peer (.*);
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			got_q.push_back(rx_data);
		end
		if (rx_frame_err === 1'b1) begin
			n_ferr++;
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		check_count++;
		if (seen !== want) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic end_of_test;
		if (n_fail == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic set_mode(input line_mode_t m, input logic slow);
		int i;
		mode_req <= m;
		slow_slew_req <= slow;
		tick(2);
		for (i = 0; i < 2000 && mode_busy !== 1'b0; i++) tick(1);
		check(mode_busy, 1'b0);
		tick(2);
		check({fast_slew_select, diff_protocol_select, half_duplex_select},
			{~slow, m != mode_rs232, m == mode_diff_half});
	endtask : set_mode
	// Holds the byte offered until an edge samples ready, or gives up after 8 edges
	task automatic push(input logic [7:0] b, output logic took);
		int i;
		tx_data <= b;
		tx_valid <= 1'b1;
		took = 1'b0;
		for (i = 0; i < 8 && !took; i++) begin
			@(posedge clk);
			took = (tx_ready === 1'b1);
		end
	endtask : push
	task automatic expect_rx(input int lim);
		int i;
		for (i = 0; i < lim && got_q.size() < exp_q.size(); i++) tick(1);
		check(got_q.size(), exp_q.size());
		foreach (exp_q[k]) if (k < got_q.size()) check(got_q[k], exp_q[k]);
		got_q.delete();
		exp_q.delete();
	endtask : expect_rx
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
	initial begin
		logic took;
		int n;
		tick(16);
		rst_n <= 1'b1;
		tick(2);
		check({fast_slew_select, diff_protocol_select, half_duplex_select}, 3'b100);
		check(board_reset_request_n, 1'b1);
		check(status_lamp_n, 5'h1F);
		for (int k = 0; k < LAMP_COUNT; k++) begin
			lamp_on <= 5'(1 << k);
			tick(3);
			check(status_lamp_n, lamp_on ^ 5'h1F);
			check(lamp_lit, lamp_on);
		end
		lamp_on <= 5'h00;
		baud_div <= 16'h0064;
		tick(3);
		check(baud_too_fast, 1'b1);
		baud_div <= 16'h007D;
		aux_mode_flow <= 1'b1;
		aux_tx <= 1'b1;
		tick(8);
		check(baud_too_fast, 1'b0);
		check(aux_rx, 1'b1);
		n = 0;
		took = 1'b1;
		while (took && n < 40) begin
			push(8'(n * 37 + 5), took);
			if (took) begin
				exp_q.push_back(8'(n * 37 + 5));
				n++;
			end
		end
		tx_valid <= 1'b0;
		check(n, 32);
		check(tx_logic_in_a, 1'b1);
		aux_tx <= 1'b0;
		expect_rx(42000);
		aux_mode_flow <= 1'b0;
		set_mode(mode_diff_full, 1'b0);
		baud_div <= 16'h000D;
		for (int k = 0; k < 4; k++) begin
			push(8'(k * 8'h55), took);
			check(took, 1'b1);
			exp_q.push_back(8'(k * 8'h55));
		end
		tx_valid <= 1'b0;
		expect_rx(1000);
		// Receiver reports mid stop bit; the enable drops after the stop bit ends
		tick(20);
		check(tx_logic_in_b, 1'b0);
		set_mode(mode_diff_full, 1'b1);
		tick(3);
		check(baud_too_fast, 1'b1);
		set_mode(mode_diff_half, 1'b0);
		push(8'hC3, took);
		check(took, 1'b1);
		tx_valid <= 1'b0;
		tick(200);
		check(tx_logic_in_b, 1'b0);
		respond_req <= 1'b1;
		for (n = 0; n < 50 && tx_logic_in_b !== 1'b1; n++) tick(1);
		check(tx_logic_in_b, 1'b1);
		tick(200);
		check(got_q.size(), 0);
		check(tx_logic_in_b, 1'b0);
		check(n_ferr, 0);
		end_of_test();
	end
endmodule : serial_line_transceiver_ctrl_tb
`default_nettype wire
